// ---- rtl/sro_defs.svh ----
`ifndef SRO_DEFS_SVH
`define SRO_DEFS_SVH

// number of control registers and their index width
`define SRO_NREG 8
`define SRO_AW 3
// register value width and coherence sequence width
`define SRO_DW 32
`define SRO_SW 16
// a stored entry is value and sequence side by side
`define SRO_EW 48
`define SRO_DATA_LSB 0
`define SRO_DATA_MSB 31
`define SRO_SEQ_LSB 32
`define SRO_SEQ_MSB 47
// value every register holds after reset
`define SRO_RST_VAL 32'h0000_0000
// the implicit reset write takes place zero in each coherence order
`define SRO_SEQ_RST 16'h0000
`define SRO_SEQ_FIRST 16'h0001
`define SRO_SEQ_ONE 16'h0001
`define SRO_SEQ_TWO 16'h0002

`endif

// ---- rtl/sro_ordering.sv ----
`timescale 1ns/10ps
`include "sro_defs.svh"

// Function
// - each register keeps one write order over all writers, starting with reset value
// - a direct write never changes results of instructions issued before it
// - direct reads see earlier direct writes to the same register at once
// - accesses before a direct write are ordered before it and see old value
// - indirect reads after a context sync see direct writes made before it
// - without a context sync an indirect read may see old or new value
module sro_ordering (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // direct accesses, one instruction per cycle in program order
  input wire logic dir_valid_i,
  input wire logic dir_write_i,
  input wire logic [`SRO_AW-1:0] dir_addr_i,
  input wire logic [`SRO_DW-1:0] dir_wdata_i,
  output logic dir_rvalid_o,
  output logic [`SRO_DW-1:0] dir_rdata_o,
  output logic [`SRO_SW-1:0] dir_rseq_o,
  // indirect accesses from hardware agents
  input wire logic ind_we_i,
  input wire logic [`SRO_AW-1:0] ind_waddr_i,
  input wire logic [`SRO_DW-1:0] ind_wdata_i,
  input wire logic ind_re_i,
  input wire logic [`SRO_AW-1:0] ind_raddr_i,
  output logic ind_rvalid_o,
  output logic [`SRO_DW-1:0] ind_rdata_o,
  output logic [`SRO_SW-1:0] ind_rseq_o,
  // synchronisation and order status
  input wire logic context_sync_event_i,
  output logic [`SRO_SW-1:0] write_seq_o
);

  logic rst_meta;
  logic rst_sync_n;
  sro_pkg::sro_state_type st;
  sro_pkg::sro_state_type next_st;
  sro_pkg::sro_entry_type mem_rd;
  logic dir_we;
  logic [`SRO_SW-1:0] dir_seq;
  logic [`SRO_SW-1:0] ind_seq;

  // direct access that asks for data back
  function automatic logic is_dir_read(input logic vld, input logic wr);
    return vld && !wr;
  endfunction

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  assign dir_we = dir_valid_i && dir_write_i;
  // single order
  // a direct write in the same cycle is placed before the indirect one
  assign dir_seq = st.seq;
  assign ind_seq = dir_we ? st.seq + `SRO_SEQ_ONE : st.seq;

  // in-order direct path
  // direct reads and writes share one in-order port, so a read sees the prior write
  sro_regmem sro_regmem_i (
    .clk_i(mclk_i),
    .rstn_i(rst_sync_n),
    .wa_en_i(dir_we),
    .wa_addr_i(dir_addr_i),
    .wa_data_i({dir_seq, dir_wdata_i}),
    .wb_en_i(ind_we_i),
    .wb_addr_i(ind_waddr_i),
    .wb_data_i({ind_seq, ind_wdata_i}),
    .re_i(is_dir_read(dir_valid_i, dir_write_i)),
    .raddr_i(dir_addr_i),
    .rdata_o(mem_rd)
  );

  always_comb begin
    next_st = st;
    next_st.dir_rvalid = is_dir_read(dir_valid_i, dir_write_i);
    next_st.ind_rvalid = ind_re_i;
    // old view served
    // indirect reads use the view before this cycle's writes
    if (ind_re_i) begin
      next_st.ind_rd = st.shadow[ind_raddr_i];
    end
    // publish at sync
    // writes seen before the sync event become visible to indirect readers
    if (context_sync_event_i) begin
      for (int i = 0; i < `SRO_NREG; i++) begin
        if (st.pend[i]) begin
          next_st.shadow[i] = st.staged[i];
        end
      end
      next_st.pend = '0;
    end
    // held until sync
    // a direct write counts after a sync in the same cycle, so it waits
    if (dir_we) begin
      next_st.staged[dir_addr_i] = {dir_seq, dir_wdata_i};
      next_st.pend[dir_addr_i] = 1'b1;
    end
    // later write wins
    // an indirect write is later in order, so it supersedes a pending direct one
    if (ind_we_i) begin
      next_st.shadow[ind_waddr_i] = {ind_seq, ind_wdata_i};
      next_st.pend[ind_waddr_i] = 1'b0;
    end
    if (dir_we && ind_we_i) begin
      next_st.seq = st.seq + `SRO_SEQ_TWO;
    end else if (dir_we || ind_we_i) begin
      next_st.seq = st.seq + `SRO_SEQ_ONE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st.pend <= '0;
      st.shadow <= {`SRO_NREG{`SRO_SEQ_RST, `SRO_RST_VAL}};
      st.staged <= {`SRO_NREG{`SRO_SEQ_RST, `SRO_RST_VAL}};
      st.seq <= `SRO_SEQ_FIRST;
      st.dir_rvalid <= 1'b0;
      st.ind_rvalid <= 1'b0;
      st.ind_rd <= {`SRO_SEQ_RST, `SRO_RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign dir_rvalid_o = st.dir_rvalid;
  assign dir_rdata_o = mem_rd[`SRO_DATA_MSB:`SRO_DATA_LSB];
  assign dir_rseq_o = mem_rd[`SRO_SEQ_MSB:`SRO_SEQ_LSB];
  assign ind_rvalid_o = st.ind_rvalid;
  assign ind_rdata_o = st.ind_rd[`SRO_DATA_MSB:`SRO_DATA_LSB];
  assign ind_rseq_o = st.ind_rd[`SRO_SEQ_MSB:`SRO_SEQ_LSB];
  assign write_seq_o = st.seq;

  AST_SEQ_STEP: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && ind_we_i) |=> st.seq == $past(st.seq) + `SRO_SEQ_TWO)
    else $error("write order did not advance by two");

  AST_SEQ_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!dir_we && !ind_we_i) |=> $stable(st.seq))
    else $error("write order moved without a write");

  AST_DIR_RAW: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && !(ind_we_i && ind_waddr_i == dir_addr_i))
    ##1 (dir_valid_i && !dir_write_i && dir_addr_i == $past(dir_addr_i))
    |=> dir_rvalid_o && dir_rdata_o == $past(dir_wdata_i, 2))
    else $error("direct read missed the earlier direct write");

  AST_FROM_READ: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_valid_i && !dir_write_i)
    ##1 (dir_we && dir_addr_i == $past(dir_addr_i))
    |-> dir_rseq_o < dir_seq)
    else $error("earlier read saw a later write");

  AST_IND_BEFORE: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && ind_re_i && ind_raddr_i == dir_addr_i)
    |=> ind_rvalid_o && ind_rseq_o != $past(dir_seq))
    else $error("indirect read affected by same cycle direct write");

  AST_SYNC_VIS: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && !ind_we_i) ##1 (context_sync_event_i && !ind_we_i && !dir_we)
    ##1 (ind_re_i && ind_raddr_i == $past(dir_addr_i, 2) && !ind_we_i)
    |=> ind_rdata_o == $past(dir_wdata_i, 3))
    else $error("indirect read after sync missed the direct write");

  AST_NO_SYNC: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && !(ind_we_i && ind_waddr_i == dir_addr_i)) |=> st.pend[$past(dir_addr_i)])
    else $error("direct write not held for a sync");

  AST_RF_ORDER: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_rvalid_o || ind_rvalid_o)
    |-> (!dir_rvalid_o || dir_rseq_o < st.seq) && (!ind_rvalid_o || ind_rseq_o < st.seq))
    else $error("read took from a write not yet in the order");

  AST_SHADOW_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!context_sync_event_i && !ind_we_i) |=> $stable(st.shadow))
    else $error("indirect view changed without a sync or indirect write");

  AST_SEQ_ONE: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we != ind_we_i) |=> st.seq == $past(st.seq) + `SRO_SEQ_ONE)
    else $error("write order did not advance by one");

  AST_IND_RAW: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    ind_we_i
    ##1 (ind_re_i && ind_raddr_i == $past(ind_waddr_i))
    |=> ind_rdata_o == $past(ind_wdata_i, 2))
    else $error("indirect read missed the earlier indirect write");

  AST_SAME_ADDR: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_we && ind_we_i && ind_waddr_i == dir_addr_i)
    ##1 (dir_valid_i && !dir_write_i && dir_addr_i == $past(dir_addr_i))
    |=> dir_rdata_o == $past(ind_wdata_i, 2))
    else $error("later indirect write lost to same cycle direct write");

  AST_DIR_NO_ANS: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (dir_valid_i && dir_write_i) |=> !dir_rvalid_o)
    else $error("direct write gave a read answer");

  AST_IND_ANS: assert property (
    @(posedge mclk_i) disable iff (!rst_sync_n)
    ind_re_i |=> ind_rvalid_o)
    else $error("indirect read request got no answer");

endmodule

// ---- rtl/sro_pkg.sv ----
`include "sro_defs.svh"

package sro_pkg;

  typedef logic [`SRO_EW-1:0] sro_entry_type;

  // state of the ordering block, except the reset synchroniser and the direct register memory
  typedef struct packed {
    logic [`SRO_NREG-1:0] pend;
    sro_entry_type [`SRO_NREG-1:0] shadow;
    sro_entry_type [`SRO_NREG-1:0] staged;
    logic [`SRO_SW-1:0] seq;
    logic dir_rvalid;
    logic ind_rvalid;
    sro_entry_type ind_rd;
  } sro_state_type;

endpackage

// ---- rtl/sro_regmem.sv ----
`timescale 1ns/10ps
`include "sro_defs.svh"

module sro_regmem (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // first write port
  input wire logic wa_en_i,
  input wire logic [`SRO_AW-1:0] wa_addr_i,
  input wire sro_pkg::sro_entry_type wa_data_i,
  // second write port, later in coherence order
  input wire logic wb_en_i,
  input wire logic [`SRO_AW-1:0] wb_addr_i,
  input wire sro_pkg::sro_entry_type wb_data_i,
  // registered read port
  input wire logic re_i,
  input wire logic [`SRO_AW-1:0] raddr_i,
  output sro_pkg::sro_entry_type rdata_o
);

  sro_pkg::sro_entry_type mem [`SRO_NREG];

  // port b overrides port a on a shared address, keeping the write order
  for (genvar i = 0; i < `SRO_NREG; i++) begin : g_word
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        mem[i] <= {`SRO_SEQ_RST, `SRO_RST_VAL};
      end else if (wb_en_i && wb_addr_i == `SRO_AW'(i)) begin
        mem[i] <= wb_data_i;
      end else if (wa_en_i && wa_addr_i == `SRO_AW'(i)) begin
        mem[i] <= wa_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= {`SRO_SEQ_RST, `SRO_RST_VAL};
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// ---- sim/sro_ordering_tb_top.sv ----
`timescale 1ns/10ps
module sro_ordering_tb_top;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic dv = 1'b0;
  logic dw = 1'b0;
  logic iw = 1'b0;
  logic ir = 1'b0;
  logic cs = 1'b0;
  logic [2:0] da = '0;
  logic [2:0] iwa = '0;
  logic [2:0] ira = '0;
  logic [31:0] dd = '0;
  logic [31:0] iwd = '0;
  logic drv, irv;
  logic [31:0] drd, ird;
  logic [15:0] drs, irs, wseq;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  sro_ordering sro_ordering_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .dir_valid_i(dv), .dir_write_i(dw), .dir_addr_i(da), .dir_wdata_i(dd),
    .dir_rvalid_o(drv), .dir_rdata_o(drd), .dir_rseq_o(drs),
    .ind_we_i(iw), .ind_waddr_i(iwa), .ind_wdata_i(iwd), .ind_re_i(ir),
    .ind_raddr_i(ira), .ind_rvalid_o(irv), .ind_rdata_o(ird), .ind_rseq_o(irs),
    .context_sync_event_i(cs), .write_seq_o(wseq));

  always #25 mclk_i = ~mclk_i;

  // the whole run needs well under a hundred cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end

  task stop_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one cycle of stimulus on both ports, applied at the falling edge
  task drive(input logic v, w, input logic [2:0] a, input logic [31:0] d,
             input logic we, input logic [2:0] wa, input logic [31:0] wd,
             input logic re, input logic [2:0] ra, input logic sy);
    @(negedge mclk_i);
    {dv, dw, da, dd} = {v, w, a, d};
    {iw, iwa, iwd} = {we, wa, wd};
    {ir, ira, cs} = {re, ra, sy};
  endtask

  task idle;
    drive(0, 0, '0, '0, 0, '0, '0, 0, '0, 0);
  endtask

  task t_reset;
    drive(1, 0, 3'h5, '0, 0, '0, '0, 0, '0, 0);
    idle();
    chk("rvalid", 32'h1, drv);
    chk("rdata", 32'h0, drd);
    chk("rseq", 32'h0, drs);
    chk("wseq", 32'h1, wseq);
  endtask

  task t_raw;
    drive(1, 1, 3'h1, 32'h1111_aaaa, 0, '0, '0, 0, '0, 0);
    drive(1, 0, 3'h1, '0, 0, '0, '0, 0, '0, 0);
    idle();
    chk("rdata", 32'h1111_aaaa, drd);
    chk("rseq", 32'h1, drs);
    chk("wseq", 32'h2, wseq);
  endtask

  task t_war;
    drive(1, 0, 3'h1, '0, 0, '0, '0, 0, '0, 0);
    drive(1, 1, 3'h1, 32'h2222_bbbb, 0, '0, '0, 0, '0, 0);
    chk("rdata", 32'h1111_aaaa, drd);
    chk("rseq", 32'h1, drs);
    idle();
    chk("rvalid", 32'h0, drv);
  endtask

  task t_sync;
    drive(0, 0, '0, '0, 0, '0, '0, 1, 3'h1, 0);
    idle();
    chk("irvalid", 32'h1, irv);
    chk("irdata", 32'h0, ird);
    drive(0, 0, '0, '0, 0, '0, '0, 0, '0, 1);
    drive(0, 0, '0, '0, 0, '0, '0, 1, 3'h1, 0);
    idle();
    chk("irdata", 32'h2222_bbbb, ird);
    chk("irseq", 32'h2, irs);
  endtask

  // direct and indirect write in one cycle; indirect read sees pre-write view
  task t_both;
    drive(1, 1, 3'h2, 32'h3333_cccc, 1, 3'h2, 32'h4444_dddd, 1, 3'h2, 0);
    drive(1, 0, 3'h2, '0, 0, '0, '0, 1, 3'h2, 0);
    chk("irdata", 32'h0, ird);
    idle();
    chk("rdata", 32'h4444_dddd, drd);
    chk("rseq", 32'h4, drs);
    chk("irdata", 32'h4444_dddd, ird);
    chk("irseq", 32'h4, irs);
    chk("wseq", 32'h5, wseq);
  endtask

  // write, sync, indirect read; a write in the sync cycle itself stays pending
  task t_walk;
    drive(1, 1, 3'h3, 32'h5555_eeee, 0, '0, '0, 0, '0, 0);
    drive(0, 0, '0, '0, 0, '0, '0, 0, '0, 1);
    drive(1, 1, 3'h4, 32'h6666_ffff, 0, '0, '0, 1, 3'h3, 1);
    drive(0, 0, '0, '0, 0, '0, '0, 1, 3'h4, 0);
    chk("irdata", 32'h5555_eeee, ird);
    chk("irseq", 32'h5, irs);
    drive(0, 0, '0, '0, 0, '0, '0, 0, '0, 1);
    chk("irdata", 32'h0, ird);
    drive(0, 0, '0, '0, 0, '0, '0, 1, 3'h4, 0);
    idle();
    chk("irdata", 32'h6666_ffff, ird);
    chk("irseq", 32'h6, irs);
    chk("wseq", 32'h7, wseq);
  endtask

  initial begin
    repeat (12) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_reset();
    t_raw();
    t_war();
    t_sync();
    t_both();
    t_walk();
    stop_test();
  end
endmodule
